// ### rtl/lcc_loop_cfg_regs.sv
/*
 loop compensation configuration register pair with decoded outputs to the
 regulator core.
 assumes a byte-command engine in front that presents one write or read per
 cycle, and an nvm restore pulse after reset.
*/
// Operation
// - alternate compensation byte at command ACh
// - alternate byte stored only, drives nothing
// - alternate gain in bits 7:6
// - alternate integrator time in bits 5:3
// - alternate ramp amplitude in bits 2:0
// - main configuration byte at command ADh
// - main bit 7 reads zero, ignores writes
// - bit 6 forces discontinuous mode in softstart
// - bit 6 ignored after softstart completes
// - bit 5 selects negative current ontime
// - bit 5 high selects shorter ontime
// - bits 4:3 select inductor 100 to 400nH
// - bits 2:0 select dc load line
`timescale 1ns/1ns
`include "lcc_map.svh"
module lcc_loop_cfg_regs (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] cmdCode,
   input wire logic wrStrobe,
   input wire logic [7:0] wrData,
   input wire logic rdStrobe,
   output lcc_pkg::lcc_byte_t rdData,
   output logic rdValid,
   output logic rdHit,
   input wire logic nvmLoad,
   input wire logic [7:0] nvmAltComp,
   input wire logic [7:0] nvmMainCfg,
   input wire logic softstartActive,
   input wire lcc_pkg::lcc_ccm_t forcedContinuousMode,
   output logic discontinuousMode,
   output logic negativeCurrentShortOntime,
   output lcc_pkg::lcc_ind_t inductorValueSelect,
   output logic [2:0] dcLoadLine
);
   import lcc_pkg::*;

   logic [7:0] altVal;
   logic [7:0] mainVal;
   logic altWr;
   logic mainWr;
   lcc_byte_t rdData_d;
   logic discMode_d;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign altWr = wrStrobe && (cmdCode == `LCC_CMD_ALT_COMP);
   assign mainWr = wrStrobe && (cmdCode == `LCC_CMD_MAIN_CFG);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   lcc_cfg_byte #(
      .WR_MASK(8'hFF)
   ) altReg (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .wrEn(altWr),
      .wrData(wrData),
      .nvmLoad(nvmLoad),
      .nvmData(nvmAltComp),
      .value(altVal)
   );

   // mask keeps bit 7 at zero on both write and restore
   lcc_cfg_byte #(
      .WR_MASK(`LCC_MAIN_WR_MASK)
   ) mainReg (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .wrEn(mainWr),
      .wrData(wrData),
      .nvmLoad(nvmLoad),
      .nvmData(nvmMainCfg),
      .value(mainVal)
   );

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_comb begin
      rdData_d = 8'h00;
      if (cmdCode == `LCC_CMD_ALT_COMP) begin
         rdData_d = altVal;
      end else if (cmdCode == `LCC_CMD_MAIN_CFG) begin
         rdData_d = mainVal;
         rdData_d[`LCC_MAIN_RSVD_BIT] = `LCC_MAIN_RSVD_VAL;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdData <= 8'h00;
         rdValid <= 1'b0;
         rdHit <= 1'b0;
      end else begin
         rdValid <= rdStrobe;
         rdHit <= rdStrobe && ((cmdCode == `LCC_CMD_ALT_COMP) ||
                               (cmdCode == `LCC_CMD_MAIN_CFG));
         if (rdStrobe) begin
            rdData <= rdData_d;
         end
      end
   end

   // ------------------------------------------------------------
   // regulator controls
   // ------------------------------------------------------------
   // the alternate byte deliberately feeds nothing below
   always_comb begin
      if (softstartActive && mainVal[`LCC_MAIN_SSDCM_BIT]) begin
         discMode_d = 1'b1;
      end else begin
         discMode_d = (forcedContinuousMode == LCC_CCM_FORCED_OFF);
      end
   end

   // registered so the power stage never sees a decode glitch
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         discontinuousMode <= 1'b0;
         negativeCurrentShortOntime <= 1'b0;
         inductorValueSelect <= LCC_IND_100NH;
         dcLoadLine <= 3'h0;
      end else begin
         discontinuousMode <= discMode_d;
         negativeCurrentShortOntime <= mainVal[`LCC_MAIN_NOCTON_BIT];
         inductorValueSelect <= lcc_ind_t'(
            mainVal[`LCC_MAIN_IND_HI:`LCC_MAIN_IND_LO]);
         dcLoadLine <= mainVal[`LCC_MAIN_DC_LOAD_LINE_HI:`LCC_MAIN_DC_LOAD_LINE_LO];
      end
   end
endmodule // lcc_loop_cfg_regs

// ### rtl/lcc_map.svh
/*
 register map of the loop compensation configuration pair: command codes,
 field positions, main write mask and reserved bit read value.
 assumes inclusion by bare name; definitions only.
*/
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH
// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define LCC_CMD_ALT_COMP 8'hAC
`define LCC_CMD_MAIN_CFG 8'hAD
// ------------------------------------------------------------
// alternate compensation fields
// ------------------------------------------------------------
`define LCC_ALT_GAIN_HI 7
`define LCC_ALT_GAIN_LO 6
`define LCC_ALT_TIME_HI 5
`define LCC_ALT_TIME_LO 3
`define LCC_ALT_RAMP_HI 2
`define LCC_ALT_RAMP_LO 0
// ------------------------------------------------------------
// main configuration fields
// ------------------------------------------------------------
`define LCC_MAIN_RSVD_BIT 7
`define LCC_MAIN_SSDCM_BIT 6
`define LCC_MAIN_NOCTON_BIT 5
`define LCC_MAIN_IND_HI 4
`define LCC_MAIN_IND_LO 3
`define LCC_MAIN_DC_LOAD_LINE_HI 2
`define LCC_MAIN_DC_LOAD_LINE_LO 0
`define LCC_MAIN_WR_MASK 8'h7F
`define LCC_MAIN_RSVD_VAL 1'b0
`endif

// ### rtl/lcc_pkg.sv
/*
 types shared by the loop compensation configuration registers.
 assumes nothing beyond a SystemVerilog compiler.
*/
package lcc_pkg;
   typedef logic [7:0] lcc_byte_t;
   typedef enum logic [1:0] {
      LCC_IND_100NH,
      LCC_IND_200NH,
      LCC_IND_300NH,
      LCC_IND_400NH
   } lcc_ind_t;
   typedef enum logic {
      LCC_CCM_FORCED_OFF,
      LCC_CCM_FORCED_ON
   } lcc_ccm_t;
endpackage

// ### rtl/lcc_cfg_byte.sv
/*
 one byte-wide configuration register with write mask and nonvolatile
 restore value.
 assumes the restore value is stable while nvmLoad is high.
*/
`timescale 1ns/1ns
module lcc_cfg_byte #(
   parameter logic [7:0] WR_MASK = 8'hFF
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic nvmLoad,
   input wire logic [7:0] nvmData,
   output logic [7:0] value
);
   logic [7:0] byte_q;
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // restore takes priority so a stale write cannot mask the nvm image
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         byte_q <= 8'h00;
      end else if (nvmLoad) begin
         byte_q <= nvmData & WR_MASK;
      end else if (wrEn) begin
         byte_q <= wrData & WR_MASK;
      end
   end
   assign value = byte_q;
endmodule // lcc_cfg_byte

// ### sim/lcc_chk_properties.sv
/* port checker for the loop config pair.
 assumes binding onto lcc_loop_cfg_regs. */
`timescale 1ns/1ns
module lcc_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] cmdCode,
   input wire logic wrStrobe,
   input wire logic [7:0] wrData,
   input wire logic rdStrobe,
   input wire lcc_pkg::lcc_byte_t rdData,
   input wire logic rdValid,
   input wire logic rdHit,
   input wire logic nvmLoad,
   input wire logic softstartActive,
   input wire lcc_pkg::lcc_ccm_t forcedContinuousMode,
   input wire logic discontinuousMode,
   input wire logic negativeCurrentShortOntime,
   input wire lcc_pkg::lcc_ind_t inductorValueSelect,
   input wire logic [2:0] dcLoadLine
);
   import lcc_pkg::*;
   // ----
   // rules
   // ----
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_rdv; rdStrobe |=> rdValid; endproperty
   a_rdv: assert property (p_rdv) else $error("read late");
   property p_one; !rdStrobe |=> !rdValid; endproperty
   a_one: assert property (p_one) else $error("stray valid");
   property p_hit; rdStrobe && cmdCode[7:1] == 7'h56 |=> rdHit; endproperty
   a_hit: assert property (p_hit) else $error("hit lost");
   property p_b7; rdStrobe && cmdCode == 8'hAD |=> !rdData[7]; endproperty
   a_b7: assert property (p_b7) else $error("bit7 set");
   property p_hold; !rdStrobe |=> $stable(rdData); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_wr; wrStrobe && cmdCode == 8'hAD && !nvmLoad ##1 !nvmLoad
      |=> {negativeCurrentShortOntime, inductorValueSelect, dcLoadLine} == $past(wrData[5:0], 2);
   endproperty
   a_wr: assert property (p_wr) else $error("field lost");
   property p_alt; wrStrobe && cmdCode == 8'hAC && !nvmLoad ##1 !nvmLoad
      |=> $stable({negativeCurrentShortOntime, inductorValueSelect, dcLoadLine});
   endproperty
   a_alt: assert property (p_alt) else $error("alt acted");
   property p_run; !softstartActive
      |=> discontinuousMode == ($past(forcedContinuousMode) == LCC_CCM_FORCED_OFF);
   endproperty
   a_run: assert property (p_run) else $error("mode wrong");
   c_hit: cover property (rdValid && rdHit);
   c_ss: cover property (softstartActive && discontinuousMode);
   c_miss: cover property (rdValid && !rdHit);
endmodule // lcc_chk
bind lcc_loop_cfg_regs lcc_chk chk_u (.*);

// ### sim/lcc_host.sv
/* host model issuing single byte commands.
 assumes requests are taken one edge after they are set. */
`timescale 1ns/1ns
module lcc_host (
   input wire logic core_clk,
   output logic [7:0] cmdCode = 8'h00,
   output logic wrStrobe = 1'b0,
   output logic [7:0] wrData = 8'h00,
   output logic rdStrobe = 1'b0,
   input wire lcc_pkg::lcc_byte_t rdData,
   input wire logic rdHit
);
   task wr(input logic [7:0] c, v);
      @(posedge core_clk);
      cmdCode <= c;
      wrData <= v;
      wrStrobe <= 1'b1;
      @(posedge core_clk);
      wrStrobe <= 1'b0;
      // stale data inverted so nothing rides on a held value
      wrData <= ~v;
   endtask
   task rd(input logic [7:0] c, output logic [7:0] v, output logic hit);
      @(posedge core_clk);
      cmdCode <= c;
      rdStrobe <= 1'b1;
      @(posedge core_clk);
      rdStrobe <= 1'b0;
      #1 v = rdData;
      hit = rdHit;
   endtask
endmodule // lcc_host

// ### sim/test_loop_compensation_config_regs.sv
/* self-checking bench for the loop config pair.
 assumes the host model drives the command side. */
`timescale 1ns/1ns
module test_loop_compensation_config_regs;
   import lcc_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, nvmLoad = 1'b0, softstartActive = 1'b0, h;
   logic [7:0] nvmAltComp = 8'h00, nvmMainCfg = 8'h00, cmdCode, wrData, d;
   logic wrStrobe, rdStrobe, rdValid, rdHit, discontinuousMode, negativeCurrentShortOntime;
   lcc_byte_t rdData;
   lcc_ccm_t forcedContinuousMode = LCC_CCM_FORCED_OFF;
   lcc_ind_t inductorValueSelect;
   logic [2:0] dcLoadLine;
   int n_errors = 0, total_checks = 0;
   lcc_loop_cfg_regs dut_u (.*);
   lcc_host host_u (.*);
   initial forever #5 core_clk = ~core_clk;
   // ----
   // scenarios
   // ----
   task chk(string n, logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task t_fields;
      logic [7:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 8'(i * 8'h25);
         host_u.wr(8'hAC, ~m);
         host_u.wr(8'hAD, m);
         host_u.rd(8'hAC, d, h);
         chk("alt", d, ~m);
         chk("altHit", h, 8'h01);
         chk("altValid", rdValid, 8'h01);
         host_u.rd(8'hAD, d, h);
         chk("main", d, m & 8'h7F);
         chk("mainHit", h, 8'h01);
         chk("out", {2'b00, negativeCurrentShortOntime, inductorValueSelect, dcLoadLine},
             m & 8'h3F);
      end
   endtask
   task t_mode(logic [7:0] v, logic s, lcc_ccm_t f, logic e);
      host_u.wr(8'hAD, v);
      softstartActive <= s;
      forcedContinuousMode <= f;
      repeat (3) @(posedge core_clk);
      #1 chk("dcm", discontinuousMode, e);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      nvmAltComp <= 8'hA5;
      nvmMainCfg <= 8'hFF;
      nvmLoad <= 1'b1;
      @(posedge core_clk);
      nvmLoad <= 1'b0;
      host_u.rd(8'hAC, d, h);
      chk("nvAlt", d, 8'hA5);
      host_u.rd(8'hAD, d, h);
      chk("nvMain", d, 8'h7F);
      t_fields;
      t_mode(8'h40, 1'b1, LCC_CCM_FORCED_ON, 1'b1);
      t_mode(8'h40, 1'b0, LCC_CCM_FORCED_ON, 1'b0);
      t_mode(8'h00, 1'b1, LCC_CCM_FORCED_ON, 1'b0);
      t_mode(8'h00, 1'b1, LCC_CCM_FORCED_OFF, 1'b1);
      host_u.rd(8'hAE, d, h);
      chk("miss", {h, d[6:0]}, 8'h00);
      tally_and_finish;
   end
   initial begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
endmodule // test_loop_compensation_config_regs
